// File: shared/rtcx_pkg.sv
// Package of register map, field positions and timing constants for the extended control block
package rtcx_pkg;
	// Byte addresses reach 0x12c, hence nine address bits
	localparam int ADDR_W = 9;
	localparam int DATA_W = 32;
	localparam int REG_W = 8;
	// Printed offsets are not multiples of four: they are indices
	localparam logic [7:0] IDX_STATUS_POWER = 8'h4a;
	localparam logic [7:0] IDX_FEATURE_EN = 8'h4b;
	localparam int ADDR_SHIFT = 2;
	localparam int USER_RAM_BYTES = 114;
	localparam int RAM_AW = 7;
	// Register A fields
	localparam int A_AUX_OK = 7;
	localparam int A_INCREMENT_IN_PROGRESS = 6;
	localparam int A_BURST = 5;
	localparam int A_RSVD = 4;
	localparam int A_PWROFF = 3;
	localparam int A_RCF = 2;
	localparam int A_WF = 1;
	localparam int A_KF = 0;
	// Register B fields
	localparam int B_ABE = 7;
	localparam int B_OSC = 6;
	localparam int B_XSEL = 5;
	localparam int B_RCE = 4;
	localparam int B_PFSEL = 3;
	localparam int B_RIE = 2;
	localparam int B_WIE = 1;
	localparam int B_KSE = 0;
	localparam logic [7:0] REG_A_RESET = 8'h08;
	localparam logic [7:0] REG_B_RESET = 8'h40;
	localparam logic [7:0] RAM_CLEAR_BYTE = 8'hff;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Timing
	localparam int CLK_MHZ = 200;
	localparam int INCREMENT_IN_PROGRESS_LEAD_US = 122;
	localparam int INCREMENT_IN_PROGRESS_LEAD_CYC = INCREMENT_IN_PROGRESS_LEAD_US * CLK_MHZ;
	localparam int REC_TIME_US = 100;
	localparam int REC_CYC = REC_TIME_US * CLK_MHZ;
endpackage : rtcx_pkg

// File: verilog/rtcx_top.sv
// Extended control registers, user RAM clear and power/interrupt pins of the clock
`timescale 1ns/100ps
module rtcx_top #(
	parameter int INCREMENT_IN_PROGRESS_LEAD = rtcx_pkg::INCREMENT_IN_PROGRESS_LEAD_CYC,
	parameter int REC_CYCLES = rtcx_pkg::REC_CYC,
	parameter int RAM_BYTES = rtcx_pkg::USER_RAM_BYTES
) (
	input wire logic CLOCK,
	input wire logic RESET_N,
	input wire logic [rtcx_pkg::ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [rtcx_pkg::DATA_W-1:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [rtcx_pkg::ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [rtcx_pkg::DATA_W-1:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic RAM_CLEAR_INPUT_N,
	input wire logic KICKSTART_INPUT_N,
	input wire logic WAKEUP_ALARM,
	input wire logic UPDATE_PENDING,
	input wire logic UPDATE_ACTIVE,
	input wire logic AUX_BATTERY_PRESENT,
	input wire logic MAIN_SUPPLY_OK,
	input wire logic OTHER_IRQ_PENDING,
	input wire logic [rtcx_pkg::RAM_AW-1:0] USER_RAM_ADDR,
	input wire logic USER_RAM_WE,
	input wire logic [7:0] USER_RAM_WDATA,
	output logic [7:0] USER_RAM_RDATA,
	input wire logic EXT_RAM_ACCESS,
	output logic EXT_RAM_ADDR_INC,
	output logic INTERRUPT_O,
	output logic INTERRUPT_OE_N,
	output logic POWER_ON_O,
	output logic POWER_ON_OE_N,
	output logic SQUARE_WAVE_SEL_OSC,
	output logic AUX_BATTERY_ENABLE,
	output logic CRYSTAL_SELECT,
	output logic HOST_LOCKED
);
	import rtcx_pkg::*;

	// Synchronisers for pin and foreign inputs
	logic [1:0] s_ram_clear_input, s_ks, s_wake, s_upd, s_upa, s_aux, s_vcc, s_oth;
	logic ram_clear_input_prev_q, ram_clear_input_prev_d, ks_prev_q, ks_prev_d;
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			s_ram_clear_input <= 2'h3;
			s_ks <= 2'h3;
			s_wake <= 2'h0;
			s_upd <= 2'h0;
			s_upa <= 2'h0;
			s_aux <= 2'h0;
			s_vcc <= 2'h0;
			s_oth <= 2'h0;
		end else begin
			s_ram_clear_input <= {s_ram_clear_input[0], RAM_CLEAR_INPUT_N};
			s_ks <= {s_ks[0], KICKSTART_INPUT_N};
			s_wake <= {s_wake[0], WAKEUP_ALARM};
			s_upd <= {s_upd[0], UPDATE_PENDING};
			s_upa <= {s_upa[0], UPDATE_ACTIVE};
			s_aux <= {s_aux[0], AUX_BATTERY_PRESENT};
			s_vcc <= {s_vcc[0], MAIN_SUPPLY_OK};
			s_oth <= {s_oth[0], OTHER_IRQ_PENDING};
		end
	end
	wire ram_clear_input_n = s_ram_clear_input[1];
	wire ks_n = s_ks[1];
	wire wake_s = s_wake[1];
	wire vcc_ok = s_vcc[1];
	wire other_irq = s_oth[1];

	// Register state
	logic [REG_W-1:0] reg_a_q, reg_a_d, reg_b_q, reg_b_d;
	logic increment_in_progress_q, increment_in_progress_d;
	logic [31:0] increment_in_progress_cnt_q, increment_in_progress_cnt_d;
	logic vcc_prev_q;

	// Clear engine
	typedef enum logic [1:0] {RTCX_IDLE, RTCX_FILL, RTCX_DONE} rtcx_clr_e;
	rtcx_clr_e clr_q, clr_d;
	logic [RAM_AW-1:0] clr_idx_q, clr_idx_d;
	logic [31:0] rec_cnt_q, rec_cnt_d;
	logic [7:0] user_ram [RAM_BYTES];
	logic [7:0] ram_rdata_q;
	wire ram_clear_input_fall = ram_clear_input_prev_q && !ram_clear_input_n;
	wire ks_fall = ks_prev_q && !ks_n;
	wire locked = (rec_cnt_q != 32'h0) || (clr_q != RTCX_IDLE);

	// AXI slave
	logic aw_ok_q, aw_ok_d, w_ok_q, w_ok_d;
	logic [ADDR_W-1:0] awaddr_q, awaddr_d;
	logic [DATA_W-1:0] wdata_q, wdata_d;
	logic wstrb0_q, wstrb0_d;
	logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [DATA_W-1:0] rdata_q, rdata_d;
	logic wr_a, wr_b;
	logic [REG_W-1:0] wval;
	logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;

	always_comb begin
		aw_ok_d = aw_ok_q;
		w_ok_d = w_ok_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb0_d = wstrb0_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		wr_a = 1'b0;
		wr_b = 1'b0;
		wval = wdata_q[REG_W-1:0];
		if (S_AXI_AWVALID && !aw_ok_q && !bvalid_q) begin
			aw_ok_d = 1'b1;
			awaddr_d = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && !w_ok_q && !bvalid_q) begin
			w_ok_d = 1'b1;
			wdata_d = S_AXI_WDATA;
			wstrb0_d = S_AXI_WSTRB[0];
		end
		if (aw_ok_q && w_ok_q && !bvalid_q) begin
			aw_ok_d = 1'b0;
			w_ok_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = RESP_OKAY;
			// Registered lock flag too, so the pin and the bus agree on the last cycle
			if (locked || HOST_LOCKED)
				bresp_d = RESP_SLVERR;
			else if (awaddr_q == (ADDR_W'(IDX_STATUS_POWER) << ADDR_SHIFT))
				wr_a = wstrb0_q;
			else if (awaddr_q == (ADDR_W'(IDX_FEATURE_EN) << ADDR_SHIFT))
				wr_b = wstrb0_q;
			else
				bresp_d = RESP_SLVERR;
		end
		if (bvalid_q && S_AXI_BREADY)
			bvalid_d = 1'b0;
		if (S_AXI_ARVALID && !rvalid_q) begin
			rvalid_d = 1'b1;
			rresp_d = RESP_OKAY;
			rdata_d = '0;
			if (locked || HOST_LOCKED)
				rresp_d = RESP_SLVERR;
			else if (S_AXI_ARADDR == (ADDR_W'(IDX_STATUS_POWER) << ADDR_SHIFT))
				rdata_d = DATA_W'(reg_a_q);
			else if (S_AXI_ARADDR == (ADDR_W'(IDX_FEATURE_EN) << ADDR_SHIFT))
				rdata_d = DATA_W'(reg_b_q);
			else
				rresp_d = RESP_SLVERR;
		end else if (rvalid_q && S_AXI_RREADY) begin
			rvalid_d = 1'b0;
		end
		// Ready outputs registered from the next handshake state
		awready_d = !aw_ok_d && !bvalid_d;
		wready_d = !w_ok_d && !bvalid_d;
		arready_d = !rvalid_d;
	end

	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			aw_ok_q <= 1'b0;
			w_ok_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb0_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= '0;
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			arready_q <= 1'b1;
		end else begin
			aw_ok_q <= aw_ok_d;
			w_ok_q <= w_ok_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb0_q <= wstrb0_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			arready_q <= arready_d;
		end
	end

	// Clear engine and recovery lockout
	always_comb begin
		clr_d = clr_q;
		clr_idx_d = clr_idx_q;
		rec_cnt_d = rec_cnt_q;
		ram_clear_input_prev_d = ram_clear_input_n;
		ks_prev_d = ks_n;
		if (rec_cnt_q != 32'h0)
			rec_cnt_d = rec_cnt_q - 32'h1;
		case (clr_q)
			RTCX_IDLE: begin
				if (ram_clear_input_fall && reg_b_q[B_RCE]) begin
					clr_d = RTCX_FILL;
					clr_idx_d = '0;
					rec_cnt_d = 32'(REC_CYCLES);
				end
			end
			RTCX_FILL: begin
				if (clr_idx_q == RAM_AW'(RAM_BYTES - 1))
					clr_d = RTCX_DONE;
				else
					clr_idx_d = clr_idx_q + RAM_AW'(1);
			end
			RTCX_DONE: clr_d = RTCX_IDLE;
			default: clr_d = RTCX_IDLE;
		endcase
	end

	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			clr_q <= RTCX_IDLE;
			clr_idx_q <= '0;
			rec_cnt_q <= '0;
			ram_clear_input_prev_q <= 1'b1;
			ks_prev_q <= 1'b1;
		end else begin
			clr_q <= clr_d;
			clr_idx_q <= clr_idx_d;
			rec_cnt_q <= rec_cnt_d;
			ram_clear_input_prev_q <= ram_clear_input_prev_d;
			ks_prev_q <= ks_prev_d;
		end
	end

	// Only the user bytes live here; calendar and extended RAM sit elsewhere
	always_ff @(posedge CLOCK) begin
		if (clr_q == RTCX_FILL)
			user_ram[clr_idx_q] <= RAM_CLEAR_BYTE;
		else if (USER_RAM_WE && !locked && USER_RAM_ADDR < RAM_AW'(RAM_BYTES))
			user_ram[USER_RAM_ADDR] <= USER_RAM_WDATA;
		ram_rdata_q <= (USER_RAM_ADDR < RAM_AW'(RAM_BYTES)) ? user_ram[USER_RAM_ADDR] : 8'h00;
	end

	// Control registers; hardware set beats software clear
	always_comb begin
		reg_a_d = reg_a_q;
		reg_b_d = reg_b_q;
		increment_in_progress_d = increment_in_progress_q;
		increment_in_progress_cnt_d = increment_in_progress_cnt_q;
		if (wr_a) begin
			reg_a_d[A_BURST] = wval[A_BURST];
			reg_a_d[A_RSVD] = wval[A_RSVD];
			reg_a_d[A_PWROFF] = wval[A_PWROFF];
			reg_a_d[A_RCF] = wval[A_RCF];
			reg_a_d[A_WF] = wval[A_WF];
			reg_a_d[A_KF] = wval[A_KF];
		end
		if (wr_b)
			reg_b_d = wval;
		if (vcc_ok && !vcc_prev_q)
			reg_b_d[B_OSC] = 1'b1;
		if (clr_q == RTCX_DONE)
			reg_a_d[A_RCF] = 1'b1;
		if (wake_s)
			reg_a_d[A_WF] = 1'b1;
		if (ks_fall)
			reg_a_d[A_KF] = 1'b1;
		if ((reg_a_d[A_WF] && reg_b_d[B_WIE]) || (reg_a_d[A_KF] && reg_b_d[B_KSE]))
			reg_a_d[A_PWROFF] = 1'b0;
		// Increment bit: pending window of INCREMENT_IN_PROGRESS_LEAD cycles then the update itself
		if (s_upd[1] && !increment_in_progress_q) begin
			increment_in_progress_d = 1'b1;
			increment_in_progress_cnt_d = 32'(INCREMENT_IN_PROGRESS_LEAD);
		end else if (increment_in_progress_cnt_q != 32'h0) begin
			increment_in_progress_cnt_d = increment_in_progress_cnt_q - 32'h1;
		end else if (increment_in_progress_q && !s_upa[1] && !s_upd[1]) begin
			increment_in_progress_d = 1'b0;
		end
		reg_a_d[A_INCREMENT_IN_PROGRESS] = increment_in_progress_d;
		reg_a_d[A_AUX_OK] = s_aux[1];
	end

	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			reg_a_q <= REG_A_RESET;
			reg_b_q <= REG_B_RESET;
			increment_in_progress_q <= 1'b0;
			increment_in_progress_cnt_q <= '0;
			vcc_prev_q <= 1'b0;
		end else begin
			reg_a_q <= reg_a_d;
			reg_b_q <= reg_b_d;
			increment_in_progress_q <= increment_in_progress_d;
			increment_in_progress_cnt_q <= increment_in_progress_cnt_d;
			vcc_prev_q <= vcc_ok;
		end
	end

	// Pin drivers: output enables registered, pin data tied low
	logic irq_req;
	logic pwr_drive;
	always_comb begin
		irq_req = vcc_ok && ((reg_a_q[A_RCF] && reg_b_q[B_RIE])
			|| (reg_a_q[A_WF] && reg_b_q[B_WIE])
			|| (reg_a_q[A_KF] && reg_b_q[B_KSE])
			// Shared pin: a cleared flag alone does not release it
			|| other_irq);
		// Power fail floats the output unless kept active
		pwr_drive = !reg_a_q[A_PWROFF] && (vcc_ok || reg_b_q[B_PFSEL]);
	end

	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			INTERRUPT_OE_N <= 1'b1;
			POWER_ON_OE_N <= 1'b1;
			EXT_RAM_ADDR_INC <= 1'b0;
			USER_RAM_RDATA <= 8'h00;
			HOST_LOCKED <= 1'b0;
		end else begin
			INTERRUPT_OE_N <= !irq_req;
			POWER_ON_OE_N <= !pwr_drive;
			EXT_RAM_ADDR_INC <= EXT_RAM_ACCESS && reg_a_q[A_BURST];
			USER_RAM_RDATA <= ram_rdata_q;
			HOST_LOCKED <= locked;
		end
	end

	assign INTERRUPT_O = 1'b0;
	assign POWER_ON_O = 1'b0;
	assign SQUARE_WAVE_SEL_OSC = reg_b_q[B_OSC];
	assign AUX_BATTERY_ENABLE = reg_b_q[B_ABE];
	assign CRYSTAL_SELECT = reg_b_q[B_XSEL];
	assign S_AXI_AWREADY = awready_q;
	assign S_AXI_WREADY = wready_q;
	assign S_AXI_BVALID = bvalid_q;
	assign S_AXI_BRESP = bresp_q;
	assign S_AXI_ARREADY = arready_q;
	assign S_AXI_RVALID = rvalid_q;
	assign S_AXI_RRESP = rresp_q;
	assign S_AXI_RDATA = rdata_q;
endmodule : rtcx_top

// File: testbench/rtcx_chk.sv
// Checker of lockout, pin and bus behaviour of the extended control block
`timescale 1ns/100ps
module rtcx_chk import rtcx_pkg::*; #(
	parameter int REC_CYCLES = 20,
	parameter int RAM_BYTES = 114
) (
	input wire logic CLOCK,
	input wire logic RESET_N,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic [DATA_W-1:0] S_AXI_RDATA,
	input wire logic [1:0] S_AXI_RRESP,
	input wire logic RAM_CLEAR_INPUT_N,
	input wire logic MAIN_SUPPLY_OK,
	input wire logic EXT_RAM_ACCESS,
	input wire logic EXT_RAM_ADDR_INC,
	input wire logic INTERRUPT_O,
	input wire logic INTERRUPT_OE_N,
	input wire logic POWER_ON_O,
	input wire logic SQUARE_WAVE_SEL_OSC,
	input wire logic HOST_LOCKED
);
	int lock_cnt_q;
	int lock_cnt_d;
	always_comb begin
		lock_cnt_d = HOST_LOCKED ? lock_cnt_q + 1 : 0;
	end
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) lock_cnt_q <= 0;
		else lock_cnt_q <= lock_cnt_d;
	end
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RESET_N);
	AST_LOCK_HOLD: assert property ($rose(HOST_LOCKED) |=> HOST_LOCKED [*8])
		else $error("lockout ended too soon");
	AST_LOCK_RD: assert property (S_AXI_ARVALID && S_AXI_ARREADY && HOST_LOCKED |=>
		S_AXI_RRESP == RESP_SLVERR && S_AXI_RDATA == '0) else $error("read served in lockout");
	AST_LOCK_CAUSE: assert property ($rose(HOST_LOCKED) |-> !$past(RAM_CLEAR_INPUT_N))
		else $error("lockout without clear pin low");
	AST_LOCK_BOUND: assert property (lock_cnt_q <= RAM_BYTES + REC_CYCLES + 8)
		else $error("lockout too long");
	AST_IRQ_NOSUP: assert property (!MAIN_SUPPLY_OK [*4] |-> INTERRUPT_OE_N)
		else $error("interrupt driven without supply");
	AST_OSC_UP: assert property ($rose(MAIN_SUPPLY_OK) |-> ##[1:4] SQUARE_WAVE_SEL_OSC)
		else $error("osc output not set at power-up");
	AST_INC_CAUSE: assert property (EXT_RAM_ADDR_INC |-> $past(EXT_RAM_ACCESS))
		else $error("increment without access");
	AST_ODRAIN: assert property (INTERRUPT_O == 1'b0 && POWER_ON_O == 1'b0)
		else $error("open-drain output drives high");
	cover property ($rose(HOST_LOCKED));
	cover property ($fell(INTERRUPT_OE_N));
	cover property (EXT_RAM_ADDR_INC);
endmodule : rtcx_chk

// File: testbench/rtcx_host.sv
// Host processor model, an AXI4-Lite master with one write and one read task
`timescale 1ns/100ps
module rtcx_host (
	input wire logic CLOCK,
	output logic [rtcx_pkg::ADDR_W-1:0] S_AXI_AWADDR,
	output logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	output logic [31:0] S_AXI_WDATA,
	output logic [3:0] S_AXI_WSTRB,
	output logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_BVALID,
	output logic S_AXI_BREADY,
	output logic [rtcx_pkg::ADDR_W-1:0] S_AXI_ARADDR,
	output logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic [1:0] S_AXI_RRESP,
	input wire logic S_AXI_RVALID,
	output logic S_AXI_RREADY
);
	initial begin
		{S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
		{S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
		S_AXI_WSTRB = 4'hf;
	end
	task automatic wr(input logic [rtcx_pkg::ADDR_W-1:0] a, input logic [7:0] d,
		output logic [1:0] r);
		@(posedge CLOCK);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= {24'h0, d};
		{S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
		fork
			begin
				do @(posedge CLOCK); while (!S_AXI_AWREADY);
				S_AXI_AWVALID <= 1'b0;
			end
			begin
				do @(posedge CLOCK); while (!S_AXI_WREADY);
				S_AXI_WVALID <= 1'b0;
			end
		join
		do @(posedge CLOCK); while (!S_AXI_BVALID);
		r = S_AXI_BRESP;
		S_AXI_BREADY <= 1'b0;
	endtask : wr
	task automatic rd(input logic [rtcx_pkg::ADDR_W-1:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge CLOCK);
		S_AXI_ARADDR <= a;
		{S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
		do @(posedge CLOCK); while (!S_AXI_ARREADY);
		S_AXI_ARVALID <= 1'b0;
		do @(posedge CLOCK); while (!S_AXI_RVALID);
		d = S_AXI_RDATA;
		r = S_AXI_RRESP;
		S_AXI_RREADY <= 1'b0;
	endtask : rd
endmodule : rtcx_host

// File: testbench/rtcx_top_tb.sv
// Testbench of the extended control block
`timescale 1ns/100ps
module rtcx_top_tb;
	import rtcx_pkg::*;
	localparam logic [ADDR_W-1:0] RA = ADDR_W'(IDX_STATUS_POWER) << ADDR_SHIFT;
	localparam logic [ADDR_W-1:0] RB = ADDR_W'(IDX_FEATURE_EN) << ADDR_SHIFT;
	localparam logic [7:0] AUX = 8'h1 << A_AUX_OK;
	localparam logic [7:0] OFF = 8'h1 << A_PWROFF;
	logic CLOCK, RESET_N, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
	logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
	logic [ADDR_W-1:0] S_AXI_AWADDR, S_AXI_ARADDR;
	logic [7:0] USER_RAM_WDATA, USER_RAM_RDATA;
	logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
	logic [3:0] S_AXI_WSTRB;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
	logic RAM_CLEAR_INPUT_N, KICKSTART_INPUT_N, WAKEUP_ALARM, UPDATE_PENDING, UPDATE_ACTIVE;
	logic AUX_BATTERY_PRESENT, MAIN_SUPPLY_OK, OTHER_IRQ_PENDING, USER_RAM_WE, EXT_RAM_ACCESS;
	logic [6:0] USER_RAM_ADDR;
	logic EXT_RAM_ADDR_INC, INTERRUPT_O, INTERRUPT_OE_N, POWER_ON_O, POWER_ON_OE_N;
	logic SQUARE_WAVE_SEL_OSC, AUX_BATTERY_ENABLE, CRYSTAL_SELECT, HOST_LOCKED;
	int n_mismatch, n_compared, n_inc;
	// Short lockout keeps the run brief
	rtcx_top #(.INCREMENT_IN_PROGRESS_LEAD(8), .REC_CYCLES(20), .RAM_BYTES(USER_RAM_BYTES)) u_rtcx_top (.*);
	rtcx_host u_rtcx_host (.*);
	initial begin
		CLOCK = 1'b0;
		forever #2.5 CLOCK = ~CLOCK;
	end
	always @(posedge CLOCK) if (EXT_RAM_ADDR_INC === 1'b1) n_inc++;
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge CLOCK);
	endtask : cyc
	task automatic rg(input logic [ADDR_W-1:0] a, input logic [7:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		u_rtcx_host.rd(a, d, r);
		chk("read data", d, {24'h0, e});
		chk("read resp", {30'h0, r}, {30'h0, er});
	endtask : rg
	task automatic wg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		logic [1:0] r;
		u_rtcx_host.wr(a, d, r);
		chk("write resp", {30'h0, r}, {30'h0, RESP_OKAY});
	endtask : wg
	task automatic t_regs();
		rg(RA, REG_A_RESET | AUX, RESP_OKAY);
		rg(RB, REG_B_RESET, RESP_OKAY);
		rg('0, 8'h00, RESP_SLVERR);
		AUX_BATTERY_PRESENT <= 1'b0;
		cyc(4);
		rg(RA, REG_A_RESET, RESP_OKAY);
		AUX_BATTERY_PRESENT <= 1'b1;
		wg(RB, 8'ha0);
		cyc(2);
		chk("abe", AUX_BATTERY_ENABLE, 1'b1);
		chk("xsel", CRYSTAL_SELECT, 1'b1);
		chk("osc", SQUARE_WAVE_SEL_OSC, 1'b0);
		MAIN_SUPPLY_OK <= 1'b0;
		cyc(6);
		MAIN_SUPPLY_OK <= 1'b1;
		cyc(6);
		chk("osc", SQUARE_WAVE_SEL_OSC, 1'b1);
		wg(RA, OFF | 8'h10);
		rg(RA, AUX | OFF | 8'h10, RESP_OKAY);
	endtask : t_regs
	task automatic t_wake_kick();
		wg(RA, OFF);
		wg(RB, 8'h01);
		chk("pwr", POWER_ON_OE_N, 1'b1);
		WAKEUP_ALARM <= 1'b1;
		cyc(3);
		WAKEUP_ALARM <= 1'b0;
		cyc(5);
		chk("irq", INTERRUPT_OE_N, 1'b1);
		chk("pwr", POWER_ON_OE_N, 1'b1);
		rg(RA, AUX | OFF | 8'h02, RESP_OKAY);
		KICKSTART_INPUT_N <= 1'b0;
		cyc(3);
		KICKSTART_INPUT_N <= 1'b1;
		cyc(5);
		chk("irq", INTERRUPT_OE_N, 1'b0);
		chk("pwr", POWER_ON_OE_N, 1'b0);
		rg(RA, AUX | 8'h03, RESP_OKAY);
		wg(RA, OFF);
		cyc(2);
		chk("irq", INTERRUPT_OE_N, 1'b1);
		chk("pwr", POWER_ON_OE_N, 1'b1);
	endtask : t_wake_kick
	task automatic t_flag_irq();
		wg(RB, 8'h04);
		wg(RA, OFF | 8'h04);
		cyc(2);
		chk("irq", INTERRUPT_OE_N, 1'b0);
		OTHER_IRQ_PENDING <= 1'b1;
		wg(RA, OFF);
		cyc(2);
		chk("irq", INTERRUPT_OE_N, 1'b0);
		rg(RA, AUX | OFF, RESP_OKAY);
		OTHER_IRQ_PENDING <= 1'b0;
		cyc(4);
		chk("irq", INTERRUPT_OE_N, 1'b1);
	endtask : t_flag_irq
	task automatic t_clear();
		USER_RAM_ADDR <= 7'd5;
		USER_RAM_WDATA <= 8'h55;
		USER_RAM_WE <= 1'b1;
		cyc(1);
		USER_RAM_WE <= 1'b0;
		cyc(3);
		chk("ram", USER_RAM_RDATA, 8'h55);
		wg(RB, 8'h14);
		RAM_CLEAR_INPUT_N <= 1'b0;
		cyc(6);
		chk("locked", HOST_LOCKED, 1'b1);
		rg(RA, 8'h00, RESP_SLVERR);
		RAM_CLEAR_INPUT_N <= 1'b1;
		for (int i = 0; i < 400 && HOST_LOCKED; i++) @(posedge CLOCK);
		chk("locked", HOST_LOCKED, 1'b0);
		rg(RA, AUX | OFF | 8'h04, RESP_OKAY);
		chk("irq", INTERRUPT_OE_N, 1'b0);
		cyc(3);
		chk("ram", USER_RAM_RDATA, RAM_CLEAR_BYTE);
		USER_RAM_ADDR <= 7'(USER_RAM_BYTES - 1);
		cyc(3);
		chk("ram", USER_RAM_RDATA, RAM_CLEAR_BYTE);
		USER_RAM_WDATA <= 8'h33;
		USER_RAM_WE <= 1'b1;
		cyc(1);
		USER_RAM_WE <= 1'b0;
		wg(RA, OFF);
		wg(RB, 8'h04);
		RAM_CLEAR_INPUT_N <= 1'b0;
		cyc(8);
		chk("locked", HOST_LOCKED, 1'b0);
		rg(RA, AUX | OFF, RESP_OKAY);
		chk("ram", USER_RAM_RDATA, 8'h33);
		RAM_CLEAR_INPUT_N <= 1'b1;
	endtask : t_clear
	task automatic t_burst();
		for (int b = 0; b < 2; b++) begin
			wg(RA, b ? OFF : OFF | 8'h20);
			EXT_RAM_ACCESS <= 1'b1;
			cyc(1);
			EXT_RAM_ACCESS <= 1'b0;
			cyc(3);
			chk("increments", n_inc, 1);
		end
	endtask : t_burst
	task automatic t_pfail();
		wg(RA, 8'h04);
		cyc(2);
		chk("pwr", POWER_ON_OE_N, 1'b0);
		MAIN_SUPPLY_OK <= 1'b0;
		cyc(5);
		chk("pwr", POWER_ON_OE_N, 1'b1);
		wg(RB, 8'h0c);
		cyc(2);
		chk("pwr", POWER_ON_OE_N, 1'b0);
		chk("irq", INTERRUPT_OE_N, 1'b1);
		MAIN_SUPPLY_OK <= 1'b1;
		cyc(5);
		chk("irq", INTERRUPT_OE_N, 1'b0);
		wg(RA, OFF);
	endtask : t_pfail
	task automatic t_increment_in_progress();
		UPDATE_PENDING <= 1'b1;
		cyc(2);
		UPDATE_PENDING <= 1'b0;
		UPDATE_ACTIVE <= 1'b1;
		rg(RA, AUX | OFF | 8'h40, RESP_OKAY);
		UPDATE_ACTIVE <= 1'b0;
		rg(RA, AUX | OFF | 8'h40, RESP_OKAY);
		cyc(10);
		rg(RA, AUX | OFF, RESP_OKAY);
	endtask : t_increment_in_progress
	task automatic print_verdict();
		if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : print_verdict
	initial begin
		RESET_N = 1'b0;
		{RAM_CLEAR_INPUT_N, KICKSTART_INPUT_N, MAIN_SUPPLY_OK, AUX_BATTERY_PRESENT} = '1;
		{WAKEUP_ALARM, UPDATE_PENDING, UPDATE_ACTIVE, OTHER_IRQ_PENDING} = '0;
		{USER_RAM_WE, EXT_RAM_ACCESS, USER_RAM_ADDR, USER_RAM_WDATA} = '0;
		cyc(4);
		RESET_N <= 1'b1;
		// Status pins need their synchroniser stages before the first read
		cyc(4);
		t_regs();
		t_wake_kick();
		t_flag_irq();
		t_clear();
		t_burst();
		t_pfail();
		t_increment_in_progress();
		print_verdict();
	end
	initial begin
		cyc(20000);
		n_mismatch++;
		print_verdict();
	end
endmodule : rtcx_top_tb
bind rtcx_top rtcx_chk #(.REC_CYCLES(REC_CYCLES), .RAM_BYTES(RAM_BYTES)) u_rtcx_chk (
	.CLOCK, .RESET_N, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
	.RAM_CLEAR_INPUT_N, .MAIN_SUPPLY_OK, .EXT_RAM_ACCESS, .EXT_RAM_ADDR_INC, .INTERRUPT_O,
	.INTERRUPT_OE_N, .POWER_ON_O, .SQUARE_WAVE_SEL_OSC, .HOST_LOCKED);
